// ==== logic/run_cmd_ctrl.sv ====
// run-command arbitration: terminals, keypad and serial link to one drive enable
// assumes terminal pins are asynchronous; serial frames are decoded upstream
// Notes on behaviour
// [R1] source 2: forward input is run, reverse input picks direction only
// [R2] configurator assigns function codes 1 and 2 to two input terminals
// [R3] source 3: run commands come only from the serial link; source range 0-4
// [R4] station id 1-250, default 1; only matching frames are accepted
// [R5] protocol selector 0-2, default 0
// [R6] baud selector 0-7 default 3; frame format default 8N1
// [R7] run prevention 0 none, 1 blocks forward, 2 blocks reverse
// [R8] power-up and trip-reset starts only for terminal sources 1 or 2; source 3 also restarts on trip reset while the serial run stays set
// [R9] power-up start enabled with run active: run at once; the option bit reads 0 at the power-up look, so a held forward run needs an edge
// [R10] power-up start disabled: run must drop then rise again; a held reverse run in source 1 starts at once
// [R11] search option bit4 gives a speed search on power-up start
// [R12] no search: start from standstill in the normal pattern
// [R13] a fault trip disables the output drive at once
// [R14] trip-reset start set: resume on reset while run stays active
// [R15] restart count 0-10, default 0, limits automatic restarts
// [R16] restart delay 0-60 s, default 1.0, before each automatic restart
// [R17] search option bit2 gives a speed search on restart after trip
// [R18] restart disabled: needs reset and a fresh run edge; a held source 1 reverse run or serial run restarts on reset without one
// [R19] source 1: both inputs active means stop
// [R20] source 0: keypad run starts, stop/reset ends
// [R21] a run in a blocked direction is ignored, output stays off
// [R22] restart counter decrements per attempt; none at zero
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module run_cmd_ctrl
   import run_cmd_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // terminal inputs
   input  wire logic        forward_run_input,
   input  wire logic        reverse_run_input,
   input  wire logic        trip_reset_input,
   // fault and serial frame
   input  wire logic        fault_trip,
   input  wire logic        frame_valid,
   input  wire logic [7:0]  frame_station,
   input  wire logic        frame_run,
   input  wire logic        frame_reverse,
   // drive outputs
   output logic             drive_enable,
   output logic             drive_reverse,
   output logic             speed_search
);
   logic [2:0] cmd_source_reg;
   logic [7:0] station_reg;
   logic [1:0] protocol_reg;
   logic [2:0] baud_reg;
   logic [1:0] frame_reg;
   logic [1:0] prevent_reg;
   logic [1:0] start_opts_reg;
   logic [3:0] restart_cnt_reg;
   logic [5:0] restart_dly_reg;
   logic [9:0] delay_ds_reg;
   logic [7:0] search_opts_reg;
   logic       key_run_reg;
   logic       key_stop_reg;
   logic       ser_run_reg;
   logic       ser_rev_reg;
   logic [2:0] fwd_sync_reg;
   logic [2:0] rev_sync_reg;
   logic [2:0] rst_sync_reg;
   logic       armed_reg;
   logic [1:0] powerup_reg;
   logic       trip_reg;
   logic [3:0] tries_reg;
   logic [9:0] tenths_reg;
   logic [20:0] tick_reg;
   logic [4:0] search_cnt_reg;
   drive_state_t state_reg;
   logic       aw_hold_reg;
   logic       w_hold_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;

   logic       term_src;
   logic       fwd;
   logic       rev;
   logic       run_req;
   logic       dir_rev;
   logic       blocked;
   logic       go;
   logic       wr_fire;
   logic       fwd_rise;

   // input synchronisers; bit 0 is read only by bit 1
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fwd_sync_reg <= 3'h0;
         rev_sync_reg <= 3'h0;
         rst_sync_reg <= 3'h0;
      end else begin
         fwd_sync_reg <= {fwd_sync_reg[1:0], forward_run_input};
         rev_sync_reg <= {rev_sync_reg[1:0], reverse_run_input};
         rst_sync_reg <= {rst_sync_reg[1:0], trip_reset_input};
      end
   end

   assign fwd      = fwd_sync_reg[1];
   assign rev      = rev_sync_reg[1];
   assign fwd_rise = fwd_sync_reg[1] & ~fwd_sync_reg[2];
   assign term_src = (cmd_source_reg == SRC_FWD_REV) || (cmd_source_reg == SRC_RUN_DIR); // R8

   // command decode per source
   always_comb begin
      run_req = 1'b0;
      dir_rev = 1'b0;
      case (cmd_source_reg)
         SRC_KEYPAD: begin
            run_req = key_run_reg;                                      // R20
         end
         SRC_FWD_REV: begin
            run_req = fwd ^ rev;                                        // R19
            dir_rev = rev & ~fwd;
         end
         SRC_RUN_DIR: begin
            run_req = fwd;                                              // R1
            dir_rev = rev;
         end
         SRC_SERIAL: begin
            run_req = ser_run_reg;                                      // R3
            dir_rev = ser_rev_reg;
         end
         default: begin
            run_req = 1'b0;
         end
      endcase
   end

   assign blocked = (prevent_reg == 2'h1 && !dir_rev) || (prevent_reg == 2'h2 && dir_rev); // R7
   assign go      = run_req && !blocked && (!term_src || armed_reg);     // R21

   // arming: a held forward run at power-up needs an edge; the power-up start bit is still 0 from reset at that look
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         armed_reg   <= 1'b0;
         powerup_reg <= 2'h3;
      end else begin
         // power-up look waits until the synchroniser holds the pin level
         if (powerup_reg != 2'h0)
            powerup_reg <= powerup_reg - 2'h1;
         if (powerup_reg == 2'h1)
            armed_reg <= start_opts_reg[OPT_POWER_ON_BIT] || !fwd;      // R9 R10
         else if (powerup_reg != 2'h0)
            armed_reg <= 1'b0;
         else if (fwd_rise || !fwd)
            armed_reg <= 1'b1;
         else if (state_reg == ST_TRIP && !start_opts_reg[OPT_TRIP_START_BIT] && tries_reg == 4'h0)
            armed_reg <= 1'b0;                                          // R18
      end
   end

   // serial commands from frames for this station
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ser_run_reg <= 1'b0;
         ser_rev_reg <= 1'b0;
      end else if (frame_valid && frame_station == station_reg) begin
         ser_run_reg <= frame_run;                                      // R4
         ser_rev_reg <= frame_reverse;
      end
   end

   assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

   // register writes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_source_reg  <= SRC_KEYPAD;
         station_reg     <= STATION_DEF;
         protocol_reg    <= 2'h0;
         baud_reg        <= BAUD_DEF;
         frame_reg       <= FRAME_8N1;
         prevent_reg     <= 2'h0;
         start_opts_reg  <= 2'h0;
         restart_cnt_reg <= 4'h0;
         restart_dly_reg <= 6'h01;
         delay_ds_reg    <= DELAY_DEF_DS;
         search_opts_reg <= 8'h00;
         key_run_reg     <= 1'b0;
         key_stop_reg    <= 1'b0;
      end else begin
         key_stop_reg <= 1'b0;
         if (key_stop_reg || state_reg == ST_TRIP)
            key_run_reg <= 1'b0;
         if (wr_fire && w_strb_reg[0]) begin
            case (aw_addr_reg)
               OFF_CMD_SOURCE:  if (w_data_reg[2:0] <= SRC_MAX) cmd_source_reg <= w_data_reg[2:0];
               OFF_STATION_ID:  if (w_data_reg[7:0] != 8'h00 && w_data_reg[7:0] <= STATION_MAX)
                                   station_reg <= w_data_reg[7:0];      // R4
               OFF_PROTOCOL:    if (w_data_reg[1:0] <= PROTO_MAX) protocol_reg <= w_data_reg[1:0]; // R5
               OFF_BAUD:        baud_reg <= w_data_reg[2:0];           // R6
               OFF_FRAME:       frame_reg <= w_data_reg[1:0];          // R6
               OFF_RUN_PREVENT: if (w_data_reg[1:0] <= PREV_MAX) prevent_reg <= w_data_reg[1:0];
               OFF_START_OPTS:  start_opts_reg <= w_data_reg[1:0];
               OFF_RESTART_CNT: if (w_data_reg[3:0] <= RESTART_MAX) restart_cnt_reg <= w_data_reg[3:0]; // R15
               OFF_RESTART_DLY: if (w_data_reg[5:0] <= DELAY_MAX) begin
                  restart_dly_reg <= w_data_reg[5:0];
                  delay_ds_reg    <= 10'(w_data_reg[5:0] * 10);      // R16
               end
               OFF_SEARCH_OPTS: search_opts_reg <= w_data_reg[7:0];
               OFF_KEYPAD: begin
                  if (w_data_reg[0]) key_run_reg <= 1'b1;             // R20
                  if (w_data_reg[1]) key_stop_reg <= 1'b1;
               end
               default: ;
            endcase
         end
      end
   end

   // drive sequencer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg      <= ST_STOP;
         trip_reg       <= 1'b0;
         tries_reg      <= 4'h0;
         tenths_reg     <= 10'h000;
         tick_reg       <= 21'h0;
         search_cnt_reg <= 5'h00;
         drive_enable   <= 1'b0;
         drive_reverse  <= 1'b0;
         speed_search   <= 1'b0;
      end else begin
         case (state_reg)
            ST_STOP: begin
               if (!trip_reg)
                  tries_reg <= restart_cnt_reg;                        // R22
               if (go) begin
                  drive_reverse <= dir_rev;
                  if (trip_reg ? search_opts_reg[SEARCH_TRIP_BIT] : search_opts_reg[SEARCH_POWER_BIT]) begin
                     state_reg      <= ST_SEARCH;                       // R11 R17
                     speed_search   <= 1'b1;
                     search_cnt_reg <= 5'(SEARCH_CYCLES);
                  end else begin
                     state_reg    <= ST_RUN;                            // R12
                     drive_enable <= 1'b1;
                  end
                  trip_reg <= 1'b0;
               end
            end
            ST_SEARCH: begin
               search_cnt_reg <= search_cnt_reg - 5'h01;
               if (search_cnt_reg == 5'h01) begin
                  speed_search <= 1'b0;
                  drive_enable <= 1'b1;
                  state_reg    <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (!go) begin
                  drive_enable <= 1'b0;
                  state_reg    <= ST_STOP;
               end
            end
            ST_TRIP: begin
               if (rst_sync_reg[1] || (tries_reg != 4'h0 && term_src)) begin
                  tick_reg   <= 21'h0;
                  tenths_reg <= delay_ds_reg;
                  state_reg  <= rst_sync_reg[1] && !(term_src && start_opts_reg[OPT_TRIP_START_BIT])
                                ? ST_STOP : ST_WAIT;                    // R14 R18
                  if (!rst_sync_reg[1])
                     tries_reg <= tries_reg - 4'h1;                    // R22
               end
            end
            ST_WAIT: begin
               if (tenths_reg == 10'h000) begin
                  state_reg <= ST_STOP;                                 // R16
               end else if (tick_reg == 21'(TENTH_CYCLES - 1)) begin
                  tick_reg   <= 21'h0;
                  tenths_reg <= tenths_reg - 10'h001;
               end else begin
                  tick_reg <= tick_reg + 21'h1;
               end
            end
            default: state_reg <= ST_STOP;
         endcase
         if (fault_trip) begin
            state_reg    <= ST_TRIP;                                    // R13
            trip_reg     <= 1'b1;
            drive_enable <= 1'b0;
            speed_search <= 1'b0;
         end
      end
   end

   // AXI4-Lite write channel
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_hold_reg   <= 1'b0;
         w_hold_reg    <= 1'b0;
         aw_addr_reg   <= 8'h00;
         w_data_reg    <= 32'h0;
         w_strb_reg    <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
      end else begin
         s_axi_awready <= !aw_hold_reg && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_hold_reg && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_hold_reg  <= 1'b0;
            w_hold_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_reg <= OFF_KEYPAD && aw_addr_reg[1:0] == 2'h0) ? 2'h0 : 2'h2;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // AXI4-Lite read channel
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= 2'h0;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            case (s_axi_araddr)
               OFF_CMD_SOURCE:  s_axi_rdata <= {29'h0, cmd_source_reg};
               OFF_STATION_ID:  s_axi_rdata <= {24'h0, station_reg};
               OFF_PROTOCOL:    s_axi_rdata <= {30'h0, protocol_reg};
               OFF_BAUD:        s_axi_rdata <= {29'h0, baud_reg};
               OFF_FRAME:       s_axi_rdata <= {30'h0, frame_reg};
               OFF_RUN_PREVENT: s_axi_rdata <= {30'h0, prevent_reg};
               OFF_START_OPTS:  s_axi_rdata <= {30'h0, start_opts_reg};
               OFF_RESTART_CNT: s_axi_rdata <= {28'h0, restart_cnt_reg};
               OFF_RESTART_DLY: s_axi_rdata <= {26'h0, restart_dly_reg};
               OFF_SEARCH_OPTS: s_axi_rdata <= {24'h0, search_opts_reg};
               OFF_SERIAL_CMD:  s_axi_rdata <= {30'h0, ser_rev_reg, ser_run_reg};
               OFF_KEYPAD:      s_axi_rdata <= {31'h0, key_run_reg};
               OFF_STATUS:      s_axi_rdata <= {20'h0, tries_reg, 1'b0, state_reg, armed_reg,
                                                 speed_search, drive_reverse, drive_enable};
               default: begin
                  s_axi_rdata <= 32'h0;
                  s_axi_rresp <= 2'h2;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // checks
   a_trip_kills_drive: assert property (@(posedge clk) disable iff (!rst_n)
      fault_trip |=> !drive_enable) else $error("drive still on after trip"); // R13
   a_prevent_fwd_run: assert property (@(posedge clk) disable iff (!rst_n)
      (prevent_reg == 2'h1 && $rose(drive_enable)) |-> drive_reverse) else $error("forward ran"); // R7
   a_prevent_rev_run: assert property (@(posedge clk) disable iff (!rst_n)
      (prevent_reg == 2'h2 && $rose(drive_enable)) |-> !drive_reverse) else $error("reverse ran"); // R7
   a_both_inputs_stop: assert property (@(posedge clk) disable iff (!rst_n)
      (cmd_source_reg == SRC_FWD_REV && fwd && rev && state_reg == ST_RUN && !fault_trip)
      |=> !drive_enable) else $error("both inputs did not stop"); // R19
   a_station_filter: assert property (@(posedge clk) disable iff (!rst_n)
      (frame_valid && frame_station != station_reg) |=> $stable(ser_run_reg)) else $error("foreign frame"); // R4
   a_station_range: assert property (@(posedge clk) disable iff (!rst_n)
      station_reg != 8'h00 && station_reg <= STATION_MAX) else $error("station out of range"); // R4
   a_restart_bound: assert property (@(posedge clk) disable iff (!rst_n)
      tries_reg <= RESTART_MAX) else $error("restart count out of range"); // R15
   a_no_tries_left: assert property (@(posedge clk) disable iff (!rst_n)
      (state_reg == ST_TRIP && tries_reg == 4'h0 && !rst_sync_reg[1] && !fault_trip)
      |=> state_reg == ST_TRIP) else $error("restart with no tries"); // R22
   a_search_first: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(speed_search) |-> !drive_enable [*8]) else $error("drive during search"); // R11
   a_serial_only: assert property (@(posedge clk) disable iff (!rst_n)
      (cmd_source_reg == SRC_SERIAL && !ser_run_reg && !fault_trip) |=> !drive_enable)
      else $error("serial source ran without serial run"); // R3
   c_run_start: cover property (@(posedge clk) disable iff (!rst_n) $rose(drive_enable));
   c_trip_seen: cover property (@(posedge clk) disable iff (!rst_n) state_reg == ST_TRIP);
   c_auto_wait: cover property (@(posedge clk) disable iff (!rst_n) state_reg == ST_WAIT);
endmodule

// ==== logic/run_cmd_pkg.sv ====
// package for the run-command block: register map, field codes, reset values, timing
// assumes a 32-bit AXI4-Lite register bus and a 20 MHz clock
package run_cmd_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_CMD_SOURCE   = 8'h00;
   localparam logic [7:0] OFF_STATION_ID   = 8'h04;
   localparam logic [7:0] OFF_PROTOCOL     = 8'h08;
   localparam logic [7:0] OFF_BAUD         = 8'h0c;
   localparam logic [7:0] OFF_FRAME        = 8'h10;
   localparam logic [7:0] OFF_RUN_PREVENT  = 8'h14;
   localparam logic [7:0] OFF_START_OPTS   = 8'h18;
   localparam logic [7:0] OFF_RESTART_CNT  = 8'h1c;
   localparam logic [7:0] OFF_RESTART_DLY  = 8'h20;
   localparam logic [7:0] OFF_SEARCH_OPTS  = 8'h24;
   localparam logic [7:0] OFF_SERIAL_CMD   = 8'h28;
   localparam logic [7:0] OFF_KEYPAD       = 8'h2c;
   localparam logic [7:0] OFF_STATUS       = 8'h30;
   // command sources
   localparam logic [2:0] SRC_KEYPAD   = 3'h0;
   localparam logic [2:0] SRC_FWD_REV  = 3'h1;
   localparam logic [2:0] SRC_RUN_DIR  = 3'h2;
   localparam logic [2:0] SRC_SERIAL   = 3'h3;
   localparam logic [2:0] SRC_MAX      = 3'h4;
   // reset values and ranges
   localparam logic [7:0] STATION_DEF  = 8'h01;
   localparam logic [7:0] STATION_MAX  = 8'hfa;
   localparam logic [1:0] PROTO_MAX    = 2'h2;
   localparam logic [2:0] BAUD_DEF     = 3'h3;
   localparam logic [1:0] FRAME_8N1    = 2'h0;
   localparam logic [1:0] PREV_MAX     = 2'h2;
   localparam logic [3:0] RESTART_MAX  = 4'ha;
   localparam logic [5:0] DELAY_MAX    = 6'h3c;
   localparam logic [9:0] DELAY_DEF_DS = 10'h00a;
   // field positions
   localparam int SEARCH_TRIP_BIT = 2;
   localparam int SEARCH_POWER_BIT = 4;
   localparam int OPT_POWER_ON_BIT = 0;
   localparam int OPT_TRIP_START_BIT = 1;
   // timing: delay counted in tenths of a second
   localparam int  CLK_HZ          = 20000000;
   localparam int  TENTH_MS        = 100;
   localparam int  TENTH_CYCLES    = CLK_HZ / 1000 * TENTH_MS;
   localparam int  SEARCH_CYCLES   = 16;
   typedef enum logic [2:0] {
      ST_STOP    = 3'b000,
      ST_SEARCH  = 3'b001,
      ST_RUN     = 3'b010,
      ST_TRIP    = 3'b011,
      ST_WAIT    = 3'b100
   } drive_state_t;
endpackage

// ==== tb/run_partner.sv ====
// partner model: terminal switches and serial host facing the run block
// assumes tasks are called from the bench in the clk domain
`timescale 1ns/1ps
module run_partner (
   // clock
   input  wire logic  clk,
   // terminal levels
   output logic       fwd,
   output logic       rev,
   output logic       trip_rst,
   // serial frame
   output logic       fvalid,
   output logic [7:0] fstation,
   output logic       frun,
   output logic       frev
);
   initial begin
      {fwd, rev, trip_rst, fvalid, fstation, frun, frev} = 13'h000;
   end
   // run role and reverse role on two terminals
   task automatic terms(input logic f, input logic r);
      @(posedge clk);
      fwd <= f;
      rev <= r;
   endtask
   // frame fields scramble once the pulse ends
   task automatic frame(input logic [7:0] s, input logic ru, input logic rv);
      @(posedge clk);
      {fvalid, fstation, frun, frev} <= {1'b1, s, ru, rv};
      @(posedge clk);
      {fvalid, fstation, frun, frev} <= {1'b0, ~s, ~ru, ~rv};
   endtask
   task automatic treset();
      @(posedge clk);
      trip_rst <= 1'b1;
      repeat (4) @(posedge clk);
      trip_rst <= 1'b0;
   endtask
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for run_cmd_ctrl with a behavioural run model
// assumes a 20 MHz clock and the AXI4-Lite timing of the design
`timescale 1ns/1ps
module testbench;
   import run_cmd_pkg::*;
   logic        clk, rst_n, fault_trip;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, frame_station;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic        forward_run_input, reverse_run_input, trip_reset_input, frame_valid, frame_run;
   logic        frame_reverse, drive_enable, drive_reverse, speed_search;
   logic [1:0]  e;
   int          bad_count, checks, seed, src, prv, k;
   int          dq[$] = '{8'h04, 1, 8'h08, 0, 8'h0c, 3, 8'h10, 0, 8'h14, 0, 8'h1c, 0, 8'h20, 1};
   run_cmd_ctrl i_run_cmd_ctrl (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .forward_run_input, .reverse_run_input, .trip_reset_input, .fault_trip, .frame_valid, .frame_station,
      .frame_run, .frame_reverse, .drive_enable, .drive_reverse, .speed_search);
   run_partner i_run_partner (.clk, .fwd(forward_run_input), .rev(reverse_run_input),
      .trip_rst(trip_reset_input), .fvalid(frame_valid), .fstation(frame_station), .frun(frame_run),
      .frev(frame_reverse));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      checks++;
      if (s !== x) begin
         bad_count++;
         $display("MISMATCH %s exp %h seen %h", nm, x, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n == 40) begin
         bad_count++;
         end_sim();
      end
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      @(posedge clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      {rd_v, rs} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'b0;
      if (n == 40) begin
         bad_count++;
         end_sim();
      end
   endtask
   // expected {enable, reverse} from source, prevention and terminal levels
   function automatic logic [1:0] model(int sr, int pv, logic f, logic r);
      int en, dir;
      en = (sr == 1) ? int'(f ^ r) : (sr == 2) ? int'(f) : 0;
      dir = (sr == 1) ? int'(r & ~f) : int'(r);
      if ((pv == 1 && dir == 0) || (pv == 2 && dir == 1)) en = 0;
      return {en[0], dir[0]};
   endfunction
   initial begin
      {rst_n, fault_trip, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'h1;
      seed = 32'h60137c91;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      for (k = 0; k < dq.size(); k += 2) begin
         rd(dq[k]);
         chk("default", rd_v, dq[k+1]);
      end
      wr(OFF_STATION_ID, 32'hfb);
      rd(OFF_STATION_ID);
      chk("station", rd_v, 32'h1);
      wr(OFF_STATION_ID, 32'hfa);
      rd(OFF_STATION_ID);
      chk("station", rd_v, 32'hfa);
      wr(OFF_STATION_ID, 32'hfa);
      chk("wr okay", rs, 2'h0);
      wr(OFF_RESTART_CNT, 32'hb);
      rd(OFF_RESTART_CNT);
      chk("count", rd_v, 32'h0);
      wr(OFF_CMD_SOURCE, 32'h5);
      rd(OFF_CMD_SOURCE);
      chk("source", rd_v, 32'h0);
      rd(8'h3c);
      chk("unmapped", rd_v, 32'h0);
      chk("unmapped resp", rs, 2'h2);
      wr(8'h3c, 32'h0);
      chk("wr error", rs, 2'h2);
      $display("test registers done");
      for (src = 0; src < 5; src++) begin
         for (prv = 0; prv < 3; prv++) begin
            wr(OFF_CMD_SOURCE, src);
            wr(OFF_RUN_PREVENT, prv);
            repeat (4) begin
               i_run_partner.terms(1'b0, 1'b0);
               repeat (6) @(posedge clk);
               k = $random(seed);
               e = model(src, prv, k[0], k[1]);
               i_run_partner.terms(k[0], k[1]);
               repeat (8) @(posedge clk);
               chk("enable", drive_enable, e[1]);
               if (e[1]) chk("reverse", drive_reverse, e[0]);
               chk("search", speed_search, 1'b0);
            end
         end
      end
      $display("test terminals done");
      wr(OFF_STATION_ID, 32'h1);
      wr(OFF_RUN_PREVENT, 32'h0);
      wr(OFF_CMD_SOURCE, SRC_SERIAL);
      i_run_partner.terms(1'b1, 1'b0);
      i_run_partner.frame(8'h01, 1'b1, 1'b1);
      repeat (6) @(posedge clk);
      chk("serial run", {drive_enable, drive_reverse}, 2'b11);
      i_run_partner.frame(8'h02, 1'b0, 1'b0);
      repeat (6) @(posedge clk);
      chk("other station", drive_enable, 1'b1);
      i_run_partner.frame(8'h01, 1'b0, 1'b0);
      repeat (6) @(posedge clk);
      chk("serial stop", drive_enable, 1'b0);
      $display("test serial done");
      wr(OFF_CMD_SOURCE, SRC_RUN_DIR);
      i_run_partner.terms(1'b0, 1'b0);
      i_run_partner.terms(1'b1, 1'b0);
      repeat (8) @(posedge clk);
      chk("run", drive_enable, 1'b1);
      fault_trip <= 1'b1;
      @(posedge clk);
      fault_trip <= 1'b0;
      repeat (2) @(posedge clk);
      chk("trip off", drive_enable, 1'b0);
      i_run_partner.treset();
      repeat (20) @(posedge clk);
      chk("no restart", drive_enable, 1'b0);
      i_run_partner.terms(1'b0, 1'b0);
      i_run_partner.terms(1'b1, 1'b0);
      repeat (8) @(posedge clk);
      chk("fresh edge", drive_enable, 1'b1);
      wr(OFF_RESTART_DLY, 32'h0);
      wr(OFF_START_OPTS, 32'h2);
      fault_trip <= 1'b1;
      @(posedge clk);
      fault_trip <= 1'b0;
      i_run_partner.treset();
      repeat (30) @(posedge clk);
      chk("reset start", drive_enable, 1'b1);
      wr(OFF_START_OPTS, 32'h0);
      wr(OFF_RESTART_CNT, 32'h1);
      i_run_partner.terms(1'b0, 1'b0);
      i_run_partner.terms(1'b1, 1'b0);
      repeat (8) @(posedge clk);
      for (k = 0; k < 2; k++) begin
         fault_trip <= 1'b1;
         @(posedge clk);
         fault_trip <= 1'b0;
         repeat (20) @(posedge clk);
         chk("auto restart", drive_enable, k == 0);
      end
      $display("test trips done");
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      wr(OFF_CMD_SOURCE, SRC_RUN_DIR);
      repeat (8) @(posedge clk);
      chk("held at power-up", drive_enable, 1'b0);
      i_run_partner.terms(1'b0, 1'b0);
      i_run_partner.terms(1'b1, 1'b0);
      repeat (8) @(posedge clk);
      chk("power-up edge", drive_enable, 1'b1);
      $display("test power-up done");
      end_sim();
   end
endmodule
